// ### logic/dbp_pkg.sv
// How it works
// - A direction bit of one makes its pin an output, and zero an input.
// - A port data write updates the level on every pin set as output.
// - A port data read returns the state of all eight port bits.
// - The second port has eight input-only pins, digital or analog.
// - After reset the input port is digital and reads like the first port.
// - Setting converter power-up selects analog mode, clearing it digital.
// - Byte, halfword and word accesses are indivisible; each gets one ack.
// - After reset every general purpose pin is an input.
// - Output pins drive their data bit, input pins read their level.
package dbp_pkg;
  localparam int DBP_ADDR_W = 4;
  localparam logic [3:0] DBP_OFS_PORT_DATA = 4'h0;
  localparam logic [3:0] DBP_OFS_PORT_DIR = 4'h4;
  localparam logic [3:0] DBP_OFS_IN_DATA = 4'h8;
  localparam logic [3:0] DBP_OFS_OPTION = 4'hC;
  localparam int DBP_OPT_PWR_BIT = 7;
  localparam logic [7:0] DBP_DIR_RST = 8'h00;
  localparam logic [7:0] DBP_DATA_RST = 8'h00;
  localparam logic [7:0] DBP_OPT_RST = 8'h00;
endpackage

// ### logic/dbp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dbp_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Data
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= '0;
      o_q <= '0;
    end else begin
      stage1 <= i_d;
      o_q <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### logic/dbp_top.sv
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dbp_top
  import dbp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [DBP_ADDR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Bidirectional port pins
  input wire logic [WIDTH-1:0] I_PORT_IN,
  output logic [WIDTH-1:0] O_PORT_OUT,
  output logic [WIDTH-1:0] O_PORT_OE_N,
  // Input-only port pins
  input wire logic [WIDTH-1:0] I_INPORT_IN,
  output logic O_ANALOG_MODE
);
  // Register state and its next values.
  logic [WIDTH-1:0] port_dir;
  logic [WIDTH-1:0] port_data;
  logic converter_power_up;
  logic [WIDTH-1:0] next_port_dir;
  logic [WIDTH-1:0] next_port_data;
  logic next_converter_power_up;

  // Pin levels after the two-stage synchronisers.
  logic [WIDTH-1:0] port_pins;
  logic [WIDTH-1:0] inport_pins;

  // Values that software sees on a read.
  logic [WIDTH-1:0] port_state;
  logic [WIDTH-1:0] inport_state;
  logic [WIDTH-1:0] rd_byte;
  logic rd_pwr;
  logic [31:0] next_rdata;
  logic next_ack;

  // A request is taken once; the registered ack blocks a second take.
  wire req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire rd_req = req & ~I_WB_WE;
  wire wr_lane0 = req & I_WB_WE & I_WB_SEL[0];

  // Address decode.
  wire hit_data = (I_WB_ADR == DBP_OFS_PORT_DATA);
  wire hit_dir = (I_WB_ADR == DBP_OFS_PORT_DIR);
  wire hit_in = (I_WB_ADR == DBP_OFS_IN_DATA);
  wire hit_opt = (I_WB_ADR == DBP_OFS_OPTION);

  // Write strobes; the input port has none, so writes to it are dropped.
  wire wr_data = wr_lane0 & hit_data;
  wire wr_dir = wr_lane0 & hit_dir;
  wire wr_opt = wr_lane0 & hit_opt;

  dbp_sync #(.WIDTH(WIDTH)) u_sync_port (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_d(I_PORT_IN),
    .o_q(port_pins)
  );
  dbp_sync #(.WIDTH(WIDTH)) u_sync_inport (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_d(I_INPORT_IN),
    .o_q(inport_pins)
  );

  // Per-bit next values, pin drive and read-back.
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      assign next_port_dir[b] = wr_dir ? I_WB_DAT[b] : port_dir[b];

      // The latch takes data whatever the direction, so a later switch
      // to output drives what was written while the bit was an input.
      assign next_port_data[b] = wr_data ? I_WB_DAT[b] :
                                 port_data[b];

      assign O_PORT_OUT[b] = port_data[b];
      assign O_PORT_OE_N[b] = ~port_dir[b];

      // Output bits read back their latch, input bits their pin.
      assign port_state[b] = port_dir[b] ? port_data[b] :
                             port_pins[b];

      // In analog mode the digital input buffer reads as zero.
      assign inport_state[b] = converter_power_up ? 1'b0 :
                               inport_pins[b];
    end
  endgenerate

  assign next_converter_power_up = wr_opt ? I_WB_DAT[DBP_OPT_PWR_BIT] :
                                   converter_power_up;

  // Read data selection; unmapped offsets read as zero.
  assign rd_byte = ({WIDTH{hit_data}} & port_state) |
                   ({WIDTH{hit_dir}} & port_dir) |
                   ({WIDTH{hit_in}} & inport_state);
  assign rd_pwr = hit_opt & converter_power_up;
  assign next_rdata = {{(32 - WIDTH){1'b0}}, rd_byte} |
                      (32'(rd_pwr) << DBP_OPT_PWR_BIT);

  // Every access gets exactly one ack, so each transfer is indivisible.
  assign next_ack = req;

  // Direction bits come up as inputs after reset.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      port_dir <= DBP_DIR_RST;
    end else begin
      port_dir <= next_port_dir;
    end
  end

  // Output latch.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      port_data <= DBP_DATA_RST;
    end else begin
      port_data <= next_port_data;
    end
  end

  // The input port comes up digital after reset.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      converter_power_up <= DBP_OPT_RST[DBP_OPT_PWR_BIT];
    end else begin
      converter_power_up <= next_converter_power_up;
    end
  end

  // The ack falls in the cycle after it rose.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= next_ack;
    end
  end

  // Read data stands until the next read replaces it.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_DAT <= 32'h00000000;
    end else if (rd_req) begin
      O_WB_DAT <= next_rdata;
    end
  end

  assign O_ANALOG_MODE = converter_power_up;
endmodule
`default_nettype wire

// ### sim/dbp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dbp_props (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  // Port outputs
  input wire logic O_ANALOG_MODE,
  input wire logic [7:0] O_PORT_OUT,
  input wire logic [7:0] O_PORT_OE_N
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  wire tk = I_WB_CYC & I_WB_STB & !O_WB_ACK;
  wire wr = tk & I_WB_WE & I_WB_SEL[0];
  ack_next_a: assert property (tk |=> O_WB_ACK) else $error("ack");
  ack_pulse_a: assert property (O_WB_ACK
    |=> !O_WB_ACK) else $error("ack2");
  dir_write_a: assert property (wr && I_WB_ADR == 4'h4
    |=> O_PORT_OE_N == ~$past(I_WB_DAT[7:0])) else $error("dir");
  dat_write_a: assert property (wr && I_WB_ADR == 4'h0
    |=> O_PORT_OUT == $past(I_WB_DAT[7:0])) else $error("dat");
  dat_hold_a: assert property (!(wr && I_WB_ADR == 4'h0)
    |=> $stable(O_PORT_OUT)) else $error("hold");
  dir_hold_a: assert property (!(wr && I_WB_ADR == 4'h4)
    |=> $stable(O_PORT_OE_N)) else $error("dir2");
  pwr_bit_a: assert property (wr && I_WB_ADR == 4'hC
    |=> O_ANALOG_MODE == $past(I_WB_DAT[7])) else $error("opt");
  gap_read_a: assert property (tk && !I_WB_WE && I_WB_ADR == 4'h2
    |=> O_WB_DAT == 32'h0) else $error("gap");
  in_ro_a: assert property (wr && I_WB_ADR == 4'h8
    |=> $stable(O_ANALOG_MODE)) else $error("ro");
endmodule
bind dbp_top dbp_props u_props (.I_CLOCK, .I_RST, .I_WB_CYC, .I_WB_STB,
  .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .O_WB_DAT, .O_WB_ACK,
  .O_ANALOG_MODE, .O_PORT_OUT, .O_PORT_OE_N);
`default_nettype wire

// ### sim/dbp_pins.sv
`timescale 1ns/1ps
`default_nettype none
module dbp_pins (
  // Bidirectional port as driven by the block
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe_n,
  // Switch settings at the far side
  input wire logic [7:0] i_sw,
  input wire logic [7:0] i_sw2,
  // Levels seen on the pins
  output logic [7:0] o_pin,
  output logic [7:0] o_inpin
);
  assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_sw);
  assign o_inpin = i_sw2;
endmodule
`default_nettype wire

// ### sim/tb_dual_byte_port_io.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_byte_port_io;
  logic clk = 0, rst = 1, cyc = 0, we = 0, ack, am, irq_en = 1;
  logic [3:0] adr = 0, sel = 4'hF;
  logic [31:0] dat = 0, rd, exp_q[$];
  logic [7:0] oe_n, pout, pin, inpin, sw, sw2, d, r;
  integer errors = 0, n_checks = 0, seed = 32'hC1EED69F;
  always #2.5 clk = ~clk;
  dbp_top uut (.I_CLOCK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(cyc),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
    .O_WB_DAT(rd), .O_WB_ACK(ack), .I_PORT_IN(pin), .O_PORT_OUT(pout),
    .O_PORT_OE_N(oe_n), .I_INPORT_IN(inpin), .O_ANALOG_MODE(am));
  dbp_pins far (.i_out(pout), .i_oe_n(oe_n), .i_sw(sw), .i_sw2(sw2),
    .o_pin(pin), .o_inpin(inpin));
  task chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) errors++;
    if (s !== e) $display("BAD %0t %h %h", $time, s, e);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) if (ack && !we) chk(rd, exp_q.pop_front());
  task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    int n;
    n = 0;
    if (!w) exp_q.push_back({24'h0, v});
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    do begin
      @(posedge clk);
      n++;
    end while (!ack && n < 9);
    if (!ack) errors++;
    if (!ack) wrap_up;
    cyc <= 0;
    @(posedge clk);
  endtask
  task rmw(input logic [7:0] m, input logic [7:0] now);
    logic keep;
    keep = irq_en;
    irq_en = 0;
    bus(0, 4'h0, now);
    bus(1, 4'h0, rd[7:0] | m);
    irq_en = keep;
  endtask
  initial begin
    sw = 8'($random(seed));
    sw2 = 8'($random(seed));
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk({24'h0, oe_n}, 32'hFF);
    chk({31'h0, am}, 32'h0);
    bus(0, 4'h4, 8'h00);
    bus(0, 4'h0, sw);
    bus(0, 4'h8, sw2);
    repeat (6) begin
      d = 8'($random(seed));
      r = 8'($random(seed));
      bus(1, 4'h0, d);
      bus(1, 4'h4, r);
      bus(0, 4'h0, (r & d) | (~r & sw));
      chk({24'h0, ~oe_n}, {24'h0, r});
      chk({24'h0, pout}, {24'h0, d});
    end
    $display("bidir port done");
    bus(1, 4'h8, 8'hFF);
    bus(0, 4'h4, r);
    bus(0, 4'h8, sw2);
    sel <= 4'hE;
    bus(1, 4'h0, ~d);
    sel <= 4'hF;
    bus(1, 4'h2, 8'hFF);
    bus(0, 4'h2, 8'h00);
    bus(0, 4'h0, (r & d) | (~r & sw));
    rmw(8'h01, (r & d) | (~r & sw));
    chk({24'h0, pout}, {24'h0, (r & d) | (~r & sw) | 8'h01});
    chk({31'h0, irq_en}, 32'h1);
    $display("refusals done");
    bus(1, 4'hC, 8'h80);
    chk({31'h0, am}, 32'h1);
    bus(0, 4'hC, 8'h80);
    bus(0, 4'h8, 8'h00);
    bus(1, 4'hC, 8'h00);
    chk({31'h0, am}, 32'h0);
    bus(0, 4'h8, sw2);
    $display("input port done");
    wrap_up;
  end
endmodule
`default_nettype wire
